// ---- lin_baud_gen.sv ----
`timescale 1ns/100ps
module lin_baud_gen (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic tick_en,
  input wire logic restart,
  input wire logic [7:0] half_div,
  output logic half_tick,
  output logic phase
);
  logic [7:0] cnt_q;
  logic phase_q;

  // one half-bit every half_div base ticks
  assign half_tick = tick_en && !restart && (cnt_q == half_div - 8'h01);
  assign phase = phase_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
      phase_q <= 1'b0;
    end else if (restart) begin
      cnt_q <= 8'h00;
      phase_q <= 1'b0;
    end else if (tick_en) begin
      if (half_tick) begin
        cnt_q <= 8'h00;
        phase_q <= ~phase_q;
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end
endmodule // lin_baud_gen

// ---- lin_capable_async_serial_port.sv ----
`timescale 1ns/100ps
module lin_capable_async_serial_port (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic unit_clock_run,
  input wire logic [lin_uart_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [lin_uart_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [lin_uart_pkg::DATA_W-1:0] reg_rdata,
  input wire logic serial_rx_pin,
  output logic serial_tx_pin,
  output logic transmit_complete_irq,
  output logic receive_complete
);
  import lin_uart_pkg::*;

  logic run;
  logic unit_power_gate_q;
  logic transmit_enable_bit_q;
  logic receive_enable_bit_q;
  logic len8_q;
  logic [2:0] brk_len_q;
  logic msb_first_q;
  logic tx_inv_q;
  logic [7:0] baud_div_q;
  logic [2:0] base_clock_select_reg_q;
  logic [7:0] pre_q;
  logic [7:0] pre_lim;
  logic base_tick;
  logic [7:0] div_eff;
  logic tx_on_q;
  logic rx_on_q;
  logic wr_mode;
  logic wr_lctl;
  logic wr_txb;
  logic wr_rxst;
  logic rd_rxb;

  tx_state_t tx_state_q;
  logic [7:0] transmit_shift_reg_q;
  logic [7:0] transmit_buffer_q;
  logic transmit_buffer_full_flag_q;
  logic transmit_shift_busy_flag;
  logic [4:0] tx_cnt_q;
  logic [1:0] gap_cnt_q;
  logic brk_req_q;
  logic irq_q;
  logic tx_line;
  logic tx_pin_q;
  logic start_char;
  logic start_brk;
  logic tx_restart;
  logic tx_load;
  logic tx_half;
  logic tx_phase;
  logic tx_bit;

  rx_state_t rx_state_q;
  logic rx_s;
  logic rx_prev_q;
  logic [7:0] rx_sh_q;
  logic [4:0] rx_cnt_q;
  logic [7:0] rx_data_q;
  logic [7:0] rx_word;
  logic rx_rdy_q;
  logic rx_ferr_q;
  logic rx_ovr_q;
  logic brk_flag_q;
  logic [3:0] low_cnt_q;
  logic done_q;
  logic rx_restart;
  logic rx_half;
  logic rx_phase;
  logic rx_sample;
  logic rx_got;
  logic rx_bad;
  logic brk_hit;

  function automatic logic [7:0] reorder(input logic [7:0] v, input logic l8, input logic msb);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) r[i] = v[7-i];
    if (!msb) reorder = v;
    else if (l8) reorder = r;
    else reorder = {1'b0, r[7:1]};
  endfunction

  // with the unit clock stopped nothing below moves but the receive synchronizer
  assign run = unit_clock_run;
  assign wr_mode = reg_wr && (reg_addr == OFS_MODE);
  assign wr_lctl = reg_wr && (reg_addr == OFS_LCTL);
  assign wr_txb = reg_wr && (reg_addr == OFS_TXB);
  assign wr_rxst = reg_wr && (reg_addr == OFS_RXST);
  assign rd_rxb = reg_rd && (reg_addr == OFS_RXB);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      unit_power_gate_q <= MODE_RST[POWER_BIT];
      transmit_enable_bit_q <= MODE_RST[TXE_BIT];
      receive_enable_bit_q <= MODE_RST[RXE_BIT];
      len8_q <= MODE_RST[LEN8_BIT];
      brk_len_q <= LCTL_RST[BRKLEN_LSB +: 3];
      msb_first_q <= LCTL_RST[DIR_BIT];
      tx_inv_q <= LCTL_RST[INV_BIT];
      baud_div_q <= BAUD_RST;
      base_clock_select_reg_q <= CKSEL_RST;
    end else if (run && reg_wr) begin
      if (wr_mode) begin
        unit_power_gate_q <= reg_wdata[POWER_BIT];
        transmit_enable_bit_q <= reg_wdata[TXE_BIT];
        receive_enable_bit_q <= reg_wdata[RXE_BIT];
        len8_q <= reg_wdata[LEN8_BIT];
      end
      if (wr_lctl) begin
        brk_len_q <= reg_wdata[BRKLEN_LSB +: 3];
        msb_first_q <= reg_wdata[DIR_BIT];
        tx_inv_q <= reg_wdata[INV_BIT];
      end
      if (reg_addr == OFS_BAUD) baud_div_q <= reg_wdata;
      if (reg_addr == OFS_CKSEL) base_clock_select_reg_q <= reg_wdata[2:0];
    end
  end

  // base clock: sys_clk divided by 2**select
  assign pre_lim = (8'h01 << base_clock_select_reg_q) - 8'h01;
  assign base_tick = run && unit_power_gate_q && (pre_q == pre_lim);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) pre_q <= 8'h00;
    else if (run) pre_q <= (!unit_power_gate_q || base_tick) ? 8'h00 : pre_q + 8'h01;
  end

  assign div_eff = (baud_div_q < MIN_DIV) ? MIN_DIV : baud_div_q;

  // enables take effect only on a base clock edge
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tx_on_q <= 1'b0;
      rx_on_q <= 1'b0;
    end else if (run) begin
      if (!unit_power_gate_q) begin
        tx_on_q <= 1'b0;
        rx_on_q <= 1'b0;
      end else if (base_tick) begin
        tx_on_q <= transmit_enable_bit_q;
        rx_on_q <= receive_enable_bit_q;
      end
    end
  end

  // separate timing for each direction
  lin_baud_gen u_tx_baud (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tick_en(base_tick),
    .restart(tx_restart),
    .half_div(div_eff),
    .half_tick(tx_half),
    .phase(tx_phase)
  );

  lin_baud_gen u_rx_baud (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tick_en(base_tick),
    .restart(rx_restart),
    .half_div(div_eff),
    .half_tick(rx_half),
    .phase(rx_phase)
  );

  assign tx_bit = tx_half && tx_phase;
  assign start_brk = (tx_state_q == TX_IDLE) && brk_req_q && !transmit_buffer_full_flag_q;
  assign start_char = ((tx_state_q == TX_IDLE) && transmit_buffer_full_flag_q)
    || ((tx_state_q == TX_GAP) && base_tick && (gap_cnt_q == GAP_TICKS - 2'h1));
  assign tx_restart = run && tx_on_q && (start_char || start_brk);
  assign tx_load = run && tx_on_q && start_char;
  assign transmit_shift_busy_flag = (tx_state_q != TX_IDLE);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tx_state_q <= TX_IDLE;
      transmit_shift_reg_q <= 8'h00;
      tx_cnt_q <= 5'h00;
      gap_cnt_q <= 2'h0;
      irq_q <= 1'b0;
    end else if (run) begin
      irq_q <= 1'b0;
      if (!tx_on_q) begin
        tx_state_q <= TX_IDLE;
      end else begin
        case (tx_state_q)
          TX_IDLE: begin
            if (start_brk) begin
              tx_state_q <= TX_BRK;
              tx_cnt_q <= BRK_TX_MIN + {2'h0, brk_len_q};
            end else if (start_char) begin
              tx_state_q <= TX_START;
              transmit_shift_reg_q <= reorder(transmit_buffer_q, len8_q, msb_first_q);
            end
          end
          TX_START: begin
            if (tx_bit) begin
              tx_state_q <= TX_DATA;
              tx_cnt_q <= len8_q ? LAST_BIT8 : LAST_BIT7;
            end
          end
          TX_DATA: begin
            if (tx_bit) begin
              transmit_shift_reg_q <= {1'b1, transmit_shift_reg_q[7:1]};
              tx_cnt_q <= tx_cnt_q - 5'h01;
              if (tx_cnt_q == 5'h00) tx_state_q <= TX_STOP;
            end
          end
          TX_STOP: begin
            if (tx_bit) begin
              irq_q <= 1'b1;
              if (transmit_buffer_full_flag_q) begin
                tx_state_q <= TX_GAP;
                gap_cnt_q <= 2'h0;
              end else begin
                tx_state_q <= TX_IDLE;
              end
            end
          end
          TX_GAP: begin
            if (start_char) begin
              tx_state_q <= TX_START;
              transmit_shift_reg_q <= reorder(transmit_buffer_q, len8_q, msb_first_q);
            end else if (base_tick) begin
              gap_cnt_q <= gap_cnt_q + 2'h1;
            end
          end
          TX_BRK: begin
            if (tx_bit) begin
              tx_cnt_q <= tx_cnt_q - 5'h01;
              if (tx_cnt_q == 5'h01) tx_state_q <= TX_STOP;
            end
          end
          default: tx_state_q <= TX_IDLE;
        endcase
      end
    end
  end

  // buffer write beats the hand-over clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      transmit_buffer_q <= 8'h00;
      transmit_buffer_full_flag_q <= 1'b0;
    end else if (run) begin
      if (!tx_on_q) begin
        transmit_buffer_full_flag_q <= 1'b0;
      end else if (wr_txb) begin
        transmit_buffer_q <= reg_wdata;
        transmit_buffer_full_flag_q <= 1'b1;
      end else if (tx_load) begin
        transmit_buffer_full_flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) brk_req_q <= 1'b0;
    else if (run) begin
      if (!tx_on_q) brk_req_q <= 1'b0;
      else if (wr_lctl && reg_wdata[BRKREQ_BIT]) brk_req_q <= 1'b1;
      else if (start_brk) brk_req_q <= 1'b0;
    end
  end

  always_comb begin
    case (tx_state_q)
      TX_START: tx_line = 1'b0;
      TX_DATA: tx_line = transmit_shift_reg_q[0];
      TX_BRK: tx_line = 1'b0;
      default: tx_line = 1'b1;
    endcase
  end

  // pin flop holds its level while the clock is stopped
  always_ff @(posedge sys_clk) begin
    if (!rst_n) tx_pin_q <= 1'b1;
    else if (run) tx_pin_q <= tx_line ^ tx_inv_q;
  end

  assign serial_tx_pin = tx_pin_q;
  assign transmit_complete_irq = irq_q;

  // receive path, never inverted
  lin_sync2 u_rx_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in(serial_rx_pin),
    .sync_out(rx_s)
  );

  always_ff @(posedge sys_clk) begin
    if (!rst_n) rx_prev_q <= 1'b1;
    else if (run) rx_prev_q <= rx_s;
  end

  assign rx_sample = rx_half && !rx_phase;
  assign rx_restart = run && rx_on_q && (rx_state_q == RX_IDLE) && rx_prev_q && !rx_s;
  assign rx_got = run && rx_on_q && (rx_state_q == RX_STOP) && rx_sample && rx_s;
  assign rx_bad = run && rx_on_q && (rx_state_q == RX_STOP) && rx_sample && !rx_s;
  assign brk_hit = run && rx_on_q && rx_sample && !rx_s && (low_cnt_q == BRK_RX_BITS);
  assign rx_word = len8_q ? rx_sh_q : {1'b0, rx_sh_q[7:1]};

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rx_state_q <= RX_IDLE;
      rx_sh_q <= 8'h00;
      rx_cnt_q <= 5'h00;
    end else if (run) begin
      if (!rx_on_q) begin
        rx_state_q <= RX_IDLE;
      end else begin
        case (rx_state_q)
          RX_IDLE: if (rx_restart) rx_state_q <= RX_START;
          RX_START: begin
            if (rx_sample) begin
              rx_state_q <= rx_s ? RX_IDLE : RX_DATA;
              rx_cnt_q <= len8_q ? LAST_BIT8 : LAST_BIT7;
            end
          end
          RX_DATA: begin
            if (rx_sample) begin
              rx_sh_q <= {rx_s, rx_sh_q[7:1]};
              rx_cnt_q <= rx_cnt_q - 5'h01;
              if (rx_cnt_q == 5'h00) rx_state_q <= RX_STOP;
            end
          end
          RX_STOP: if (rx_sample) rx_state_q <= rx_s ? RX_IDLE : RX_WAIT;
          RX_WAIT: if (rx_s) rx_state_q <= RX_IDLE;
          default: rx_state_q <= RX_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) low_cnt_q <= 4'h0;
    else if (run) begin
      if (rx_s || !rx_on_q) low_cnt_q <= 4'h0;
      else if (rx_sample && (low_cnt_q != 4'hf)) low_cnt_q <= low_cnt_q + 4'h1;
    end
  end

  // flags: hardware set wins over software clear
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rx_data_q <= 8'h00;
      rx_rdy_q <= 1'b0;
      rx_ferr_q <= 1'b0;
      rx_ovr_q <= 1'b0;
      brk_flag_q <= 1'b0;
      done_q <= 1'b0;
    end else if (run) begin
      done_q <= rx_got;
      if (rx_got) rx_data_q <= reorder(rx_word, len8_q, msb_first_q);
      if (!rx_on_q) begin
        rx_rdy_q <= 1'b0;
        rx_ferr_q <= 1'b0;
        rx_ovr_q <= 1'b0;
        brk_flag_q <= 1'b0;
      end else begin
        if (rx_got) rx_rdy_q <= 1'b1;
        else if (rd_rxb) rx_rdy_q <= 1'b0;
        if (rx_got && rx_rdy_q) rx_ovr_q <= 1'b1;
        else if (wr_rxst && reg_wdata[OVR_BIT]) rx_ovr_q <= 1'b0;
        if (rx_bad) rx_ferr_q <= 1'b1;
        else if (wr_rxst && reg_wdata[FERR_BIT]) rx_ferr_q <= 1'b0;
        if (brk_hit) brk_flag_q <= 1'b1;
        else if (wr_rxst && reg_wdata[BRK_BIT]) brk_flag_q <= 1'b0;
      end
    end
  end

  assign receive_complete = done_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) reg_rdata <= 8'h00;
    else if (run) begin
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          OFS_MODE: reg_rdata <= {unit_power_gate_q, transmit_enable_bit_q, receive_enable_bit_q, 2'h0, len8_q, 2'h0};
          OFS_LCTL: reg_rdata <= {2'h0, brk_req_q, brk_len_q, msb_first_q, tx_inv_q};
          OFS_BAUD: reg_rdata <= baud_div_q;
          OFS_CKSEL: reg_rdata <= {5'h00, base_clock_select_reg_q};
          OFS_TXB: reg_rdata <= transmit_buffer_q;
          OFS_TXST: reg_rdata <= {6'h00, transmit_buffer_full_flag_q, transmit_shift_busy_flag};
          OFS_RXB: reg_rdata <= rx_data_q;
          OFS_RXST: reg_rdata <= {4'h0, rx_ovr_q, rx_ferr_q, brk_flag_q, rx_rdy_q};
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  AST_MIN_DIV: assert property (div_eff >= MIN_DIV)
    else $error("baud divisor below rate limit");
  AST_FREEZE: assert property (!unit_clock_run |=> $stable(serial_tx_pin) && $stable(tx_state_q))
    else $error("state moved while clock stopped");
  AST_INVERT: assert property ($past(unit_clock_run) |-> serial_tx_pin == ($past(tx_line) ^ $past(tx_inv_q)))
    else $error("tx pin level does not follow inversion");
  AST_START_LOW: assert property (tx_state_q == TX_START |-> !tx_line)
    else $error("start bit not low");
  AST_STOP_HIGH: assert property (tx_state_q == TX_STOP || tx_state_q == TX_IDLE |-> tx_line)
    else $error("stop or idle not high");
  AST_BRK_LOAD: assert property (tx_on_q && run && start_brk |=> tx_cnt_q == 5'(BRK_TX_MIN + $past(brk_len_q)))
    else $error("break length not taken from field");
  AST_BRK_RANGE: assert property (tx_state_q == TX_BRK |-> tx_cnt_q >= 5'h01 && tx_cnt_q <= BRK_TX_MAX)
    else $error("break length out of range");
  AST_IRQ: assert property (transmit_complete_irq |-> $past(tx_state_q) == TX_STOP && $past(tx_bit))
    else $error("complete pulse without stop bit end");
  AST_GAP: assert property ($past(tx_state_q) == TX_GAP && tx_state_q == TX_START |-> $past(gap_cnt_q) == 2'h1)
    else $error("back-to-back gap not two base clocks");
  AST_TXST: assert property (reg_rd && reg_addr == OFS_TXST && run |=>
    reg_rdata == {6'h00, $past(transmit_buffer_full_flag_q), $past(transmit_shift_busy_flag)})
    else $error("transmit status bits misplaced");
  AST_BRK_RX: assert property ($rose(brk_flag_q) |-> $past(low_cnt_q) == BRK_RX_BITS && !$past(rx_s))
    else $error("break flag at wrong low length");
  AST_RESTART: assert property (rx_restart |=> rx_state_q == RX_START)
    else $error("start bit did not restart receiver");
  AST_EN_SYNC: assert property ($rose(tx_on_q) |-> $past(base_tick) && $past(transmit_enable_bit_q))
    else $error("enable not taken on base clock");

  COV_B2B: cover property (tx_state_q == TX_GAP ##1 tx_state_q == TX_START);
  COV_BRK_TX: cover property (tx_state_q == TX_BRK ##1 tx_state_q == TX_STOP);
  COV_BRK_RX: cover property ($rose(brk_flag_q));
  COV_RX_OK: cover property (rx_got);
endmodule // lin_capable_async_serial_port

// ---- lin_capable_async_serial_port_test.sv ----
`timescale 1ns/100ps
module lin_capable_async_serial_port_test;
  import lin_uart_pkg::*;
  localparam int BIT = 64;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic run = 1'b1;
  logic inv = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic serial_rx_pin;
  logic serial_tx_pin;
  logic transmit_complete_irq;
  logic rx_done;
  int rx_done_n = 0;
  logic [7:0] got;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  always #12.5 sys_clk = ~sys_clk;
  lin_capable_async_serial_port dut (.sys_clk(sys_clk), .rst_n(rst_n), .unit_clock_run(run),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .serial_rx_pin(serial_rx_pin), .serial_tx_pin(serial_tx_pin),
    .transmit_complete_irq(transmit_complete_irq), .receive_complete(rx_done));
  lin_remote_node #(.BIT(BIT)) far (.sys_clk(sys_clk), .tx_line(serial_tx_pin), .inverted(inv),
    .rx_line(serial_rx_pin), .got(got));
  task automatic stop_test();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (rx_done === 1'b1) rx_done_n++;
    if (cycles == 40000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rchk(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    chk(16'(v), 16'(e));
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    @(posedge sys_clk);
    #1;
    while (transmit_complete_irq !== 1'b1 && n < 3000) begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk(16'(transmit_complete_irq), 16'h0001);
  endtask
  task automatic setup(input logic l8, input logic [7:0] lctl);
    wr(OFS_MODE, 8'h00);
    repeat (4) @(posedge sys_clk);
    wr(OFS_LCTL, lctl);
    wr(OFS_MODE, 8'h80);
    wr(OFS_MODE, {3'b111, 2'b00, l8, 2'b00});
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic t_tx(input logic l8, input logic [7:0] lctl, input logic [7:0] d, input logic [7:0] e);
    setup(l8, lctl);
    wr(OFS_TXB, d);
    repeat (100) @(posedge sys_clk);
    rchk(OFS_TXST, 8'h01);
    wait_irq();
    chk(16'(got), 16'(e));
    rchk(OFS_TXST, 8'h00);
  endtask
  task automatic t_break(input logic [2:0] f);
    int n;
    n = 0;
    wr(OFS_LCTL, {2'b00, 1'b1, f, 2'b00});
    while (serial_tx_pin !== 1'b0 && n < 200) begin
      @(posedge sys_clk);
      #1 n++;
    end
    n = 0;
    while (serial_tx_pin === 1'b0 && n < 2000) begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk(16'(n), 16'((13 + f) * BIT));
    wait_irq();
  endtask
  task automatic t_rx(input logic l8, input logic [7:0] d, input int n);
    int c0;
    setup(l8, 8'h00);
    c0 = rx_done_n;
    far.send(d, n);
    repeat (8) @(posedge sys_clk);
    rchk(OFS_RXB, l8 ? d : {1'b0, d[6:0]});
    chk(16'(rx_done_n - c0), 16'h0001);
  endtask
  initial begin
    logic [7:0] v;
    int n;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    rchk(OFS_MODE, MODE_RST);
    rchk(OFS_LCTL, LCTL_RST);
    rchk(OFS_BAUD, BAUD_RST);
    rchk(OFS_CKSEL, 8'(CKSEL_RST));
    rchk(OFS_TXST, 8'h00);
    wr(OFS_BAUD, 8'h20);
    rchk(OFS_BAUD, 8'h20);
    t_tx(1'b1, 8'h00, 8'ha5, 8'ha5);
    t_tx(1'b1, 8'h02, 8'h8c, 8'h31);
    t_tx(1'b0, 8'h00, 8'h35, 8'hb5);
    t_tx(1'b0, 8'h02, 8'h35, 8'hd6);
    // inverted transmit beside plain receive
    inv <= 1'b1;
    setup(1'b1, 8'h01);
    chk(16'(serial_tx_pin), 16'h0000);
    fork
      far.send(8'h3c, 8);
      begin
        wr(OFS_TXB, 8'hc3);
        wait_irq();
      end
    join
    chk(16'(got), 16'h00c3);
    rchk(OFS_RXB, 8'h3c);
    wr(OFS_LCTL, 8'h00);
    inv <= 1'b0;
    repeat (700) @(posedge sys_clk);
    t_break(3'h0);
    t_break(3'h7);
    // back-to-back: stop plus two base clocks of high
    repeat (700) @(posedge sys_clk);
    wr(OFS_TXB, 8'h00);
    v = 8'h02;
    for (n = 0; n < 50 && v[1]; n++) begin
      rd(OFS_TXST, v);
    end
    wr(OFS_TXB, 8'h00);
    wait (serial_tx_pin === 1'b1);
    n = 0;
    while (serial_tx_pin === 1'b1 && n < 500) begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk(16'(n), 16'(BIT + 2));
    wait_irq();
    chk(16'(got), 16'h0000);
    t_rx(1'b1, 8'h5a, 8);
    t_rx(1'b0, 8'hb5, 7);
    far.hold_low(10 * BIT);
    repeat (BIT) @(posedge sys_clk);
    rd(OFS_RXST, v);
    chk(16'(v[1]), 16'h0000);
    wr(OFS_RXST, 8'h0e);
    far.hold_low(13 * BIT);
    repeat (BIT) @(posedge sys_clk);
    rd(OFS_RXST, v);
    chk(16'(v[1]), 16'h0001);
    // clock stop mid-character
    setup(1'b1, 8'h00);
    wr(OFS_TXB, 8'h0f);
    repeat (150) @(posedge sys_clk);
    run <= 1'b0;
    @(posedge sys_clk);
    #1 v[0] = serial_tx_pin;
    n = 0;
    repeat (200) begin
      @(posedge sys_clk);
      #1 n += int'(serial_tx_pin !== v[0]);
    end
    chk(16'(n), 16'h0000);
    run <= 1'b1;
    wr(OFS_MODE, 8'h00);
    repeat (700) @(posedge sys_clk);
    t_tx(1'b1, 8'h00, 8'h80, 8'h80);
    stop_test();
  end
endmodule // lin_capable_async_serial_port_test

// ---- lin_remote_node.sv ----
`timescale 1ns/100ps
module lin_remote_node #(
  parameter int BIT = 64
) (
  input wire logic sys_clk,
  input wire logic tx_line,
  input wire logic inverted,
  output logic rx_line,
  output logic [7:0] got
);
  logic [7:0] sh;
  logic line;
  assign line = tx_line ^ inverted;
  initial begin
    rx_line = 1'b1;
    got = 8'h00;
  end
  // low start, data lsb first, high stop
  task automatic send(input logic [7:0] d, input int n);
    @(posedge sys_clk);
    rx_line <= 1'b0;
    repeat (BIT) @(posedge sys_clk);
    for (int i = 0; i < n; i++) begin
      rx_line <= d[i];
      repeat (BIT) @(posedge sys_clk);
    end
    rx_line <= 1'b1;
    repeat (BIT) @(posedge sys_clk);
  endtask
  task automatic hold_low(input int n);
    @(posedge sys_clk);
    rx_line <= 1'b0;
    repeat (n) @(posedge sys_clk);
    rx_line <= 1'b1;
  endtask
  // eight mid-bit samples after a confirmed start
  always begin
    @(posedge sys_clk);
    if (line === 1'b0) begin
      repeat (BIT / 2) @(posedge sys_clk);
      if (line === 1'b0) begin
        for (int i = 0; i < 8; i++) begin
          repeat (BIT) @(posedge sys_clk);
          sh = {line, sh[7:1]};
        end
        got <= sh;
      end
      wait (line === 1'b1);
    end
  end
endmodule // lin_remote_node

// ---- lin_sync2.sv ----
`timescale 1ns/100ps
module lin_sync2 (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_q;
  logic stable_q;

  // idle line level is high
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      meta_q <= 1'b1;
      stable_q <= 1'b1;
    end else begin
      meta_q <= async_in;
      stable_q <= meta_q;
    end
  end

  assign sync_out = stable_q;
endmodule // lin_sync2

// ---- lin_uart_pkg.sv ----
// Behaviour
// - Bit rate never exceeds 625 kbps; the baud divisor is clamped.
// - Characters are 7 or 8 data bits, both directions.
// - Bit timing comes from a programmable 8-bit baud divisor.
// - Transmitter and receiver run independently, full duplex.
// - Bit order selectable: MSB first or LSB first.
// - Inversion flips only the transmit pin, never the receive path.
// - Transmit sync break lasts 13 to 20 bit times.
// - Break is hardware made; length from low control bits 4 to 2.
// - Receive low longer than 11 bit times sets the break flag.
// - Clock stopped: all state but the receive synchronizer frozen, transmit pin holds last level.
// - Enables synced to base clock; re-enable two base clocks after clearing.
// - Back-to-back characters get two extra base clocks before the start bit.
// - Receiver restarts bit timing at every detected start bit.
// - Transmit-complete pulse after every character and after every break.
// - Transmit status: buffer full in bit 1, shift busy in bit 0.
package lin_uart_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int SYS_CLK_HZ = 40_000_000;
  localparam int MAX_BAUD_BPS = 625_000;
  localparam logic [7:0] MIN_DIV = 8'((SYS_CLK_HZ + 2 * MAX_BAUD_BPS - 1) / (2 * MAX_BAUD_BPS));

  localparam logic [2:0] OFS_MODE = 3'h0;
  localparam logic [2:0] OFS_LCTL = 3'h1;
  localparam logic [2:0] OFS_BAUD = 3'h2;
  localparam logic [2:0] OFS_CKSEL = 3'h3;
  localparam logic [2:0] OFS_TXB = 3'h4;
  localparam logic [2:0] OFS_TXST = 3'h5;
  localparam logic [2:0] OFS_RXB = 3'h6;
  localparam logic [2:0] OFS_RXST = 3'h7;

  localparam int POWER_BIT = 7;
  localparam int TXE_BIT = 6;
  localparam int RXE_BIT = 5;
  localparam int LEN8_BIT = 2;
  localparam int BRKREQ_BIT = 5;
  localparam int BRKLEN_LSB = 2;
  localparam int DIR_BIT = 1;
  localparam int INV_BIT = 0;
  localparam int FULL_BIT = 1;
  localparam int BUSY_BIT = 0;
  localparam int RDY_BIT = 0;
  localparam int BRK_BIT = 1;
  localparam int FERR_BIT = 2;
  localparam int OVR_BIT = 3;

  localparam logic [7:0] MODE_RST = 8'h04;
  localparam logic [7:0] LCTL_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'hff;
  localparam logic [2:0] CKSEL_RST = 3'h0;

  localparam logic [4:0] BRK_TX_MIN = 5'h0d;
  localparam logic [4:0] BRK_TX_MAX = 5'h14;
  localparam logic [3:0] BRK_RX_BITS = 4'hb;
  localparam logic [1:0] GAP_TICKS = 2'h2;
  localparam logic [4:0] LAST_BIT8 = 5'h07;
  localparam logic [4:0] LAST_BIT7 = 5'h06;

  typedef enum logic [5:0] {
    TX_IDLE = 6'h01,
    TX_START = 6'h02,
    TX_DATA = 6'h04,
    TX_STOP = 6'h08,
    TX_GAP = 6'h10,
    TX_BRK = 6'h20
  } tx_state_t;

  typedef enum logic [4:0] {
    RX_IDLE = 5'h01,
    RX_START = 5'h02,
    RX_DATA = 5'h04,
    RX_STOP = 5'h08,
    RX_WAIT = 5'h10
  } rx_state_t;
endpackage
